// >>> hdl/bma_pkg.sv
package bma_pkg;

  // ---------------------------------------------------------------
  // Synchroniser and timing
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_STAGES      = 2;
  localparam logic [1:0]  SYNC_RESET       = 2'h3;
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned AS_IDLE_EDGES    = 2;
  localparam logic [1:0]  AS_IDLE_COUNT    = 2'h2;
  localparam logic [1:0]  AS_IDLE_RESET    = 2'h0;

  // ---------------------------------------------------------------
  // Processor arbiter states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    BMA_OWN     = 5'h01,
    BMA_GRANT   = 5'h02,
    BMA_HOLD    = 5'h04,
    BMA_DROP    = 5'h08,
    BMA_FLOAT   = 5'h10
  } bma_arb_e;

  // ---------------------------------------------------------------
  // Alternate master states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    BMA_M_IDLE  = 4'h1,
    BMA_M_REQ   = 4'h2,
    BMA_M_WAIT  = 4'h4,
    BMA_M_OWN   = 4'h8
  } bma_mst_e;

endpackage : bma_pkg

// >>> hdl/bma_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bma_if;
  // Request, driven high and low by the alternate master alone
  logic master_request_n;
  logic master_grant_n;
  // Acknowledge, driven high and low by the alternate master
  logic grant_acknowledge_n;
  logic address_strobe_n;
  logic locked_cycle_n;
  logic async_cycle_term_n;
  logic sync_cycle_term_n;
  // Processor bus buffers floated
  logic bus_float;

  modport cpu (
    input  master_request_n,
    input  grant_acknowledge_n,
    output master_grant_n,
    output address_strobe_n,
    output locked_cycle_n,
    output bus_float,
    input  async_cycle_term_n,
    input  sync_cycle_term_n
  );

  modport alt (
    output master_request_n,
    output grant_acknowledge_n,
    input  master_grant_n,
    input  address_strobe_n,
    input  locked_cycle_n,
    input  bus_float,
    input  async_cycle_term_n,
    input  sync_cycle_term_n
  );
endinterface : bma_if
`default_nettype wire

// >>> hdl/bma_cpu.sv
// Overview of operation
// - One owner; processor has lowest priority.
// - Request, then grant, then acknowledge.
// - Request may arrive at any time.
// - Grant deferred until decided cycle starts.
// - No grant while locked sequence runs.
// - Granted master arbitrates, holds acknowledge.
// - Take bus: granted, strobe idle, floated.
// - Optionally wait for termination idle.
// - Never take bus while acknowledge active.
// - Requests are wired-OR onto one line; here the one alternate master drives it push-pull.
// - External priority picks among requesters.
// - Grant drops after acknowledge; re-grant pending.
// - Requests recognised in reset, halt, fault; SYS_RST here holds the synchronisers idle and ignores them.
// - Current cycle finishes before release.
// - Request withdrawn unacknowledged: processor takes bus back.
// - Grant may pass daisy chain or encoder.
// - Request and acknowledge synchronised, two clocks.
// - Float after strobe and lock negate.
// - Grant or acknowledge floats the bus.
// - Grant held until ack or drop; float until ack and request clear.
`timescale 1ns/1ps
`default_nettype none
module bma_cpu (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic SYS_RST,
  // Link
  bma_if.cpu        LINK,
  // Processor bus controller side
  input  wire logic CYCLE_START,
  input  wire logic CYCLE_DONE,
  input  wire logic CYCLE_LOCKED,
  input  wire logic LOCK_DONE,
  output logic      CYCLE_BUSY,
  output logic      BUS_OWNED
);

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic req_n_sync;
  logic ack_n_sync;
  logic req;
  logic ack;

  bma_sync bma_sync_req_i (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .d_in    (LINK.master_request_n),
    .q_out   (req_n_sync)
  );

  bma_sync bma_sync_ack_i (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .d_in    (LINK.grant_acknowledge_n),
    .q_out   (ack_n_sync)
  );

  assign req = ~req_n_sync;
  assign ack = ~ack_n_sync;

  // ---------------------------------------------------------------
  // Bus cycle and lock
  // ---------------------------------------------------------------
  logic as_n_reg;
  logic lock_n_reg;
  logic pend_reg;
  logic grant_ok;
  logic can_start;
  bma_pkg::bma_arb_e state_reg;
  bma_pkg::bma_arb_e state_next;

  assign grant_ok  = ~pend_reg & lock_n_reg;
  assign can_start = (state_reg == bma_pkg::BMA_OWN) & ~req & ~ack;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_reg <= 1'b0;
    end else if (CYCLE_START & can_start & as_n_reg & ~pend_reg) begin
      pend_reg <= 1'b1;
    end else begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      as_n_reg <= 1'b1;
    end else if (pend_reg) begin
      as_n_reg <= 1'b0;
    end else if (CYCLE_DONE) begin
      as_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_n_reg <= 1'b1;
    end else if (pend_reg & CYCLE_LOCKED) begin
      lock_n_reg <= 1'b0;
    end else if (LOCK_DONE & as_n_reg) begin
      lock_n_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Arbiter state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bma_pkg::BMA_OWN: begin
        if (ack) begin
          state_next = bma_pkg::BMA_FLOAT;
        end else if (req & grant_ok) begin
          state_next = bma_pkg::BMA_GRANT;
        end
      end
      bma_pkg::BMA_GRANT: begin
        state_next = bma_pkg::BMA_HOLD;
      end
      bma_pkg::BMA_HOLD: begin
        if (ack | ~req) begin
          state_next = bma_pkg::BMA_DROP;
        end
      end
      bma_pkg::BMA_DROP: begin
        state_next = bma_pkg::BMA_FLOAT;
      end
      bma_pkg::BMA_FLOAT: begin
        if (~ack & ~req) begin
          state_next = bma_pkg::BMA_OWN;
        end else if (req & lock_n_reg) begin
          state_next = bma_pkg::BMA_GRANT;
        end
      end
      default: begin
        state_next = bma_pkg::BMA_OWN;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= bma_pkg::BMA_OWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic grant_n_reg;
  logic float_reg;
  logic owned_reg;
  logic busy_reg;
  logic tri_ctl;

  assign tri_ctl = (state_next != bma_pkg::BMA_OWN);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      grant_n_reg <= 1'b1;
      float_reg   <= 1'b0;
      owned_reg   <= 1'b1;
    end else begin
      grant_n_reg <= ~((state_next == bma_pkg::BMA_GRANT) |
                       (state_next == bma_pkg::BMA_HOLD));
      float_reg   <= tri_ctl & as_n_reg & lock_n_reg & ~pend_reg;
      owned_reg   <= ~(tri_ctl & as_n_reg & lock_n_reg & ~pend_reg);
    end
  end

  // ---------------------------------------------------------------
  // Cycle status
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_reg <= 1'b0;
    end else if (pend_reg) begin
      busy_reg <= 1'b1;
    end else if (CYCLE_DONE) begin
      busy_reg <= 1'b0;
    end
  end

  assign LINK.master_grant_n   = grant_n_reg;
  assign LINK.address_strobe_n = as_n_reg;
  assign LINK.locked_cycle_n   = lock_n_reg;
  assign LINK.bus_float        = float_reg;

  assign CYCLE_BUSY = busy_reg;
  assign BUS_OWNED  = owned_reg;

endmodule : bma_cpu

// ---------------------------------------------------------------
// Two-stage input synchroniser
// ---------------------------------------------------------------
module bma_sync (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic SYS_RST,
  // Data
  input  wire logic d_in,
  output logic      q_out
);

  // Only the second stage is read outside
  logic [1:0] stage_reg;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stage_reg <= bma_pkg::SYNC_RESET;
    end else begin
      stage_reg <= {stage_reg[0], d_in};
    end
  end

  assign q_out = stage_reg[1];

endmodule : bma_sync
`default_nettype wire

// >>> hdl/bma_alt.sv
`timescale 1ns/1ps
`default_nettype none
module bma_alt (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic SYS_RST,
  // Link
  bma_if.alt        LINK,
  // User side
  input  wire logic NEED_BUS,
  input  wire logic WIN_PRIORITY,
  input  wire logic WAIT_TERM,
  output logic      MASTER_ACTIVE
);

  // ---------------------------------------------------------------
  // Master state machine
  // ---------------------------------------------------------------
  bma_pkg::bma_mst_e state_reg;
  logic [1:0]        idle_cnt_reg;
  logic              req_n_reg;
  logic              ack_n_reg;
  logic              active_reg;
  logic              term_idle;

  assign term_idle = ~WAIT_TERM | (LINK.async_cycle_term_n & LINK.sync_cycle_term_n);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idle_cnt_reg <= bma_pkg::AS_IDLE_RESET;
    end else if (state_reg != bma_pkg::BMA_M_WAIT | ~LINK.address_strobe_n) begin
      idle_cnt_reg <= bma_pkg::AS_IDLE_RESET;
    end else if (idle_cnt_reg != bma_pkg::AS_IDLE_COUNT) begin
      idle_cnt_reg <= idle_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= bma_pkg::BMA_M_IDLE;
      req_n_reg <= 1'b1;
      ack_n_reg <= 1'b1;
      active_reg <= 1'b0;
    end else begin
      case (state_reg)
        bma_pkg::BMA_M_IDLE: begin
          if (NEED_BUS) begin
            req_n_reg <= 1'b0;
            state_reg <= bma_pkg::BMA_M_REQ;
          end
        end
        bma_pkg::BMA_M_REQ: begin
          if (~NEED_BUS) begin
            req_n_reg <= 1'b1;
            state_reg <= bma_pkg::BMA_M_IDLE;
          end else if (~LINK.master_grant_n & WIN_PRIORITY) begin
            state_reg <= bma_pkg::BMA_M_WAIT;
          end
        end
        bma_pkg::BMA_M_WAIT: begin
          if (~NEED_BUS) begin
            req_n_reg <= 1'b1;
            state_reg <= bma_pkg::BMA_M_IDLE;
          end else if ((idle_cnt_reg == bma_pkg::AS_IDLE_COUNT) & LINK.bus_float &
                       ~LINK.master_grant_n & LINK.grant_acknowledge_n & term_idle) begin
            ack_n_reg <= 1'b0;
            active_reg <= 1'b1;
            req_n_reg <= 1'b1;
            state_reg <= bma_pkg::BMA_M_OWN;
          end
        end
        bma_pkg::BMA_M_OWN: begin
          if (~NEED_BUS) begin
            ack_n_reg <= 1'b1;
            active_reg <= 1'b0;
            state_reg <= bma_pkg::BMA_M_IDLE;
          end
        end
        default: begin
          state_reg <= bma_pkg::BMA_M_IDLE;
        end
      endcase
    end
  end

  // Push-pull: drives both high and low
  assign LINK.master_request_n    = req_n_reg;
  assign LINK.grant_acknowledge_n = ack_n_reg;
  assign MASTER_ACTIVE            = active_reg;

endmodule : bma_alt
`default_nettype wire

// >>> bench/bma_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bma_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Link
  input wire logic master_request_n,
  input wire logic master_grant_n,
  input wire logic grant_acknowledge_n,
  input wire logic address_strobe_n,
  input wire logic locked_cycle_n,
  input wire logic bus_float
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_req_held;
    (!master_request_n && grant_acknowledge_n) [*4];
  endsequence
  sequence s_ack_held;
    !grant_acknowledge_n [*4];
  endsequence
  property p_lock;
    $fell(master_grant_n) |-> locked_cycle_n;
  endproperty
  property p_cause;
    $fell(master_grant_n) |-> !$past(master_request_n, 2) || !$past(master_request_n, 3)
      || !$past(master_request_n, 4) || !$past(master_request_n, 5);
  endproperty
  property p_take;
    $fell(grant_acknowledge_n) |-> !$past(master_grant_n) && $past(bus_float)
      && $past(address_strobe_n) && $past(address_strobe_n, 2);
  endproperty
  property p_one;
    bus_float |-> address_strobe_n;
  endproperty
  property p_float;
    $rose(bus_float) |-> address_strobe_n && locked_cycle_n;
  endproperty
  property p_hold;
    s_req_held ##0 !master_grant_n |=> !master_grant_n;
  endproperty
  property p_drop;
    $fell(grant_acknowledge_n) |-> ##[1:6] master_grant_n;
  endproperty
  property p_keep;
    s_ack_held ##0 bus_float |=> bus_float;
  endproperty
  property p_back;
    (master_request_n && grant_acknowledge_n) [*6] |-> !bus_float;
  endproperty
  a_lock: assert property (p_lock) else $error("grant while locked");
  a_cause: assert property (p_cause) else $error("grant without request");
  a_take: assert property (p_take) else $error("bus taken too early");
  a_one: assert property (p_one) else $error("two owners");
  a_float: assert property (p_float) else $error("float during cycle");
  a_hold: assert property (p_hold) else $error("grant dropped early");
  a_drop: assert property (p_drop) else $error("grant not dropped");
  a_keep: assert property (p_keep) else $error("float lost");
  a_back: assert property (p_back) else $error("bus not returned");
endmodule : bma_asserts
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, sys_rst, c_start, c_done, c_lock, l_done, busy, owned;
  logic need, win, w_term, active;
  int   num_errors, n_checks;
  bma_if link ();
  bma_cpu bma_cpu_i (.CLK(clk), .SYS_RST(sys_rst), .LINK(link), .CYCLE_START(c_start),
    .CYCLE_DONE(c_done), .CYCLE_LOCKED(c_lock), .LOCK_DONE(l_done), .CYCLE_BUSY(busy),
    .BUS_OWNED(owned));
  bma_alt bma_alt_i (.CLK(clk), .SYS_RST(sys_rst), .LINK(link), .NEED_BUS(need),
    .WIN_PRIORITY(win), .WAIT_TERM(w_term), .MASTER_ACTIVE(active));
  bma_asserts bma_asserts_i (.CLK(clk), .SYS_RST(sys_rst),
    .master_request_n(link.master_request_n), .master_grant_n(link.master_grant_n),
    .grant_acknowledge_n(link.grant_acknowledge_n), .address_strobe_n(link.address_strobe_n),
    .locked_cycle_n(link.locked_cycle_n), .bus_float(link.bus_float));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  always #50 clk = ~clk;
  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic wt(ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 60) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(s, v);
  endtask : wt
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic start(input logic lk);
    @(posedge clk) c_start <= 1'b1;
    c_lock <= lk;
    wt(busy, 1'b1);
    @(posedge clk) c_start <= 1'b0;
  endtask : start
  task automatic pulse_done;
    @(posedge clk) c_done <= 1'b1;
    @(posedge clk) c_done <= 1'b0;
  endtask : pulse_done
  task automatic release_bus;
    @(posedge clk) need <= 1'b0;
    wt(active, 1'b0);
    wt(owned, 1'b1);
  endtask : release_bus
  task automatic summarize;
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_idle;
    @(posedge clk) need <= 1'b1;
    wt(active, 1'b1);
    chk(owned, 1'b0);
    release_bus();
  endtask : t_idle
  task automatic t_mid;
    start(1'b0);
    @(posedge clk) need <= 1'b1;
    idle(10);
    chk(owned, 1'b1);
    chk(active, 1'b0);
    pulse_done();
    wt(active, 1'b1);
    release_bus();
  endtask : t_mid
  task automatic t_lock;
    start(1'b1);
    @(posedge clk) need <= 1'b1;
    pulse_done();
    idle(10);
    chk(link.master_grant_n, 1'b1);
    @(posedge clk) l_done <= 1'b1;
    @(posedge clk) l_done <= 1'b0;
    c_lock <= 1'b0;
    wt(link.master_grant_n, 1'b0);
    wt(active, 1'b1);
    release_bus();
  endtask : t_lock
  task automatic t_withdraw;
    @(posedge clk) win <= 1'b0;
    need <= 1'b1;
    wt(link.master_grant_n, 1'b0);
    idle(5);
    chk(active, 1'b0);
    @(posedge clk) need <= 1'b0;
    idle(10);
    chk(owned, 1'b1);
    chk(link.master_grant_n, 1'b1);
    @(posedge clk) win <= 1'b1;
  endtask : t_withdraw
  task automatic t_term;
    @(posedge clk) w_term <= 1'b1;
    link.async_cycle_term_n <= 1'b0;
    link.sync_cycle_term_n <= 1'b0;
    need <= 1'b1;
    idle(15);
    chk(active, 1'b0);
    @(posedge clk) link.async_cycle_term_n <= 1'b1;
    idle(10);
    chk(active, 1'b0);
    @(posedge clk) link.sync_cycle_term_n <= 1'b1;
    wt(active, 1'b1);
    release_bus();
    @(posedge clk) w_term <= 1'b0;
  endtask : t_term
  initial begin
    {clk, c_start, c_done, c_lock, l_done, need, w_term, num_errors, n_checks} = '0;
    {sys_rst, win, link.async_cycle_term_n, link.sync_cycle_term_n} = 4'hf;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_idle();
    t_mid();
    t_lock();
    t_withdraw();
    t_term();
    summarize();
  end
  initial begin
    #500000;
    num_errors++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
